/* File: rtl/mfhp_parser.sv */
// Function
// - 20 kb/s headers: SHR 2000 us, PHR 400 us; 250 kb/s: 160, 32.
// - Payload 200/400 use 100 kb/s headers; 500/1000 use 250 kb/s.
// - First two MPDU octets form the 16-bit frame control word.
// - Bits 2:0 give type: beacon, data, ack, command; 4-7 reserved.
// - Filter passes only types 0, 1 and 3 by default (never ack), in auto-ack or basic mode.
// - Types above 3 accepted only with reserved-type upload enable set.
// - Bit 3 flags security; the filter does not evaluate it.
// - Auto-ack to data request sets pending bit from configured value.
// - Auto-ack mode acks non-broadcast data/command with bit 5 set.
// - Auto-retry mode waits for ack if bit 5 set, else finishes.
// - Both addresses present and bit 6 set: source PAN ID omitted.
// - Dest mode bits 11:10, source 15:14; 0 none, 1 rsvd, 2 short, 3 ext.
// - Modes 2 or 3: 16-bit PAN ID then 16- or 64-bit address.
// - Bits 13:12 give version; 2 and 3 handled under configuration.
// - Auto-ack decision uses frame version and configured accept level.
// - Sequence number after frame control is copied into the ack.
// - Destination fields parsed before source fields, each when present.
// - Auxiliary security header present only when bit 3 is one.
// - Last two payload octets are the checksum footer.
// - Filter inputs: type, address modes, version.
// - PHR low seven bits are length; top bit kept, not in length.
// - Frames with zero length are never reported.
`include "mfhp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mfhp_parser (
    input wire logic sys_clk,
    input wire logic rst,
    input wire mfhp_pkg::mfhp_octet_t rx_octet,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_is_tx,
    input wire mfhp_pkg::mfhp_cfg_t cfg,
    output mfhp_pkg::mfhp_hdr_t hdr,
    output logic hdr_valid,
    output mfhp_pkg::mfhp_result_t result,
    output logic [18:0] shr_cycles,
    output logic [17:0] phr_cycles,
    output logic [17:0] ack_deadline_cycles,
    output logic [7:0] phr_out
);
    typedef enum logic [1:0]
    {
        ST_PHR = 2'b00,
        ST_BODY = 2'b01,
        ST_SKIP = 2'b10
    } st_t;

    localparam int W = $bits(mfhp_pkg::mfhp_octet_t);

    mfhp_pkg::mfhp_octet_t oct;
    logic oct_valid;
    logic oct_take;
    st_t st_q;
    logic [6:0] idx_q;
    logic [6:0] len_q;
    logic msb_q;
    logic [15:0] fc_q;
    logic [7:0] seq_q;
    logic [7:0] cmd_q;
    logic bcast_q;
    logic [6:0] dst_off;
    logic [6:0] src_off;
    logic [6:0] aux_off;
    logic [6:0] dst_len;
    logic [6:0] src_len;
    logic [6:0] cmd_off;
    logic type_ok;
    logic ver_ok;
    logic pass;
    logic is_tx_q;
    logic done_q;
    mfhp_pkg::mfhp_hdr_t hdr_q;
    mfhp_pkg::mfhp_result_t res_q;

    mfhp_fifo #(
        .WIDTH(W),
        .DEPTH(`MFHP_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(rx_octet),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .out_data(oct),
        .out_valid(oct_valid),
        .out_ready(oct_take)
    );

    // Stall drain while a result is being presented
    assign oct_take = !done_q;

    function automatic logic [6:0] addr_len(input logic [1:0] mode,
                                            input logic with_pan);
        logic [6:0] a;
        a = '0;
        if (mode == `MFHP_AM_SHORT)
        begin
            a = `MFHP_SHORT_OCTETS;
        end
        else if (mode == `MFHP_AM_EXT)
        begin
            a = `MFHP_EXT_OCTETS;
        end
        if (mode[1] && with_pan)
        begin
            a = a + `MFHP_PAN_OCTETS;
        end
        return a;
    endfunction

    function automatic mfhp_pkg::mfhp_lclass_t len_class(input logic [6:0] l);
        if (l == `MFHP_LEN_ACK)
        begin
            return mfhp_pkg::MFHP_LC_ACK;
        end
        else if (l >= `MFHP_LEN_MIN_MPDU)
        begin
            return mfhp_pkg::MFHP_LC_MPDU;
        end
        return mfhp_pkg::MFHP_LC_RSVD;
    endfunction

    // Header field layout after FC and sequence number
    always_comb
    begin
        dst_len = addr_len(fc_q[`MFHP_FC_DMODE_LSB +: 2], 1'b1);
        src_len = addr_len(fc_q[`MFHP_FC_SMODE_LSB +: 2],
                           !(fc_q[`MFHP_FC_PANC_BIT] && dst_len != '0 &&
                             fc_q[`MFHP_FC_DMODE_LSB + 1]));
        dst_off = 7'h03;
        src_off = dst_off + dst_len;
        aux_off = src_off + src_len;
        cmd_off = fc_q[`MFHP_FC_SEC_BIT] ? 7'h7F : aux_off;
    end

    // Filter decision
    always_comb
    begin
        type_ok = (fc_q[2:0] <= `MFHP_FT_MAX_STD) ||
                  cfg.reserved_type_upload_enable;
        ver_ok = (fc_q[`MFHP_FC_VER_LSB +: 2] <= cfg.version_accept_level);
        pass = type_ok && ver_ok &&
               (fc_q[2:0] != `MFHP_FT_ACK) &&
               (fc_q[`MFHP_FC_DMODE_LSB + 1] ||
                fc_q[`MFHP_FC_SMODE_LSB + 1]);
    end

    // Octet walk
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= ST_PHR;
            idx_q <= '0;
            len_q <= '0;
            msb_q <= 1'b0;
            fc_q <= '0;
            seq_q <= '0;
            cmd_q <= '0;
            bcast_q <= 1'b0;
            is_tx_q <= 1'b0;
        end
        else if (oct_valid && oct_take)
        begin
            unique case (st_q)
                ST_PHR:
                begin
                    len_q <= oct.data[6:0];
                    msb_q <= oct.data[7];
                    is_tx_q <= rx_is_tx;
                    idx_q <= '0;
                    fc_q <= '0;
                    cmd_q <= '0;
                    bcast_q <= 1'b1;
                    st_q <= oct.last ? ST_PHR : ST_BODY;
                end
                ST_BODY, ST_SKIP:
                begin
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == 7'h00)
                    begin
                        fc_q[7:0] <= oct.data;
                    end
                    if (idx_q == 7'h01)
                    begin
                        fc_q[15:8] <= oct.data;
                    end
                    if (idx_q == 7'h02)
                    begin
                        seq_q <= oct.data;
                    end
                    if (idx_q >= 7'h03 && idx_q < src_off &&
                        idx_q >= dst_off + `MFHP_PAN_OCTETS &&
                        oct.data != `MFHP_BCAST_LO)
                    begin
                        bcast_q <= 1'b0;
                    end
                    if (idx_q == cmd_off)
                    begin
                        cmd_q <= oct.data;
                    end
                    if (oct.last || idx_q + 1'b1 == len_q)
                    begin
                        st_q <= ST_PHR;
                    end
                end
                default:
                begin
                    st_q <= ST_PHR;
                end
            endcase
        end
    end

    // Frame end: publish header and decision
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            hdr_q <= '0;
            res_q <= '0;
        end
        else if (done_q)
        begin
            done_q <= 1'b0;
            res_q.tx_done <= 1'b0;
        end
        else if (oct_valid && st_q != ST_PHR &&
                 (oct.last || idx_q + 1'b1 == len_q))
        begin
            done_q <= 1'b1;
            hdr_q.frame_type <= fc_q[2:0];
            hdr_q.security <= fc_q[`MFHP_FC_SEC_BIT];
            hdr_q.pending <= fc_q[`MFHP_FC_PEND_BIT];
            hdr_q.ack_request <= fc_q[`MFHP_FC_ACKREQ_BIT];
            hdr_q.pan_compress <= fc_q[`MFHP_FC_PANC_BIT];
            hdr_q.dst_mode <= fc_q[`MFHP_FC_DMODE_LSB +: 2];
            hdr_q.version <= fc_q[`MFHP_FC_VER_LSB +: 2];
            hdr_q.src_mode <= fc_q[`MFHP_FC_SMODE_LSB +: 2];
            hdr_q.seq_num <= seq_q;
            hdr_q.length <= len_q;
            hdr_q.phr_msb <= msb_q;
            hdr_q.lclass <= len_class(len_q);
            hdr_q.dst_offset <= dst_off;
            hdr_q.src_offset <= src_off;
            hdr_q.aux_offset <= fc_q[`MFHP_FC_SEC_BIT] ? aux_off : '0;
            hdr_q.fcs_offset <= len_q - `MFHP_FCS_OCTETS;
            hdr_q.dst_bcast <= bcast_q && fc_q[`MFHP_FC_DMODE_LSB + 1];
            hdr_q.data_request <= (fc_q[2:0] == `MFHP_FT_CMD) &&
                                  (cmd_q == `MFHP_DATA_REQ_CMD);
            res_q.filter_pass <= pass;
            res_q.report <= (len_q != '0) && (is_tx_q || pass ||
                            !cfg.auto_ack_receive_mode);
            res_q.send_ack <= !is_tx_q && cfg.auto_ack_receive_mode &&
                              pass && fc_q[`MFHP_FC_ACKREQ_BIT] &&
                              !(bcast_q && fc_q[`MFHP_FC_DMODE_LSB + 1]) &&
                              (fc_q[2:0] == `MFHP_FT_DATA ||
                               fc_q[2:0] == `MFHP_FT_CMD);
            res_q.ack_pending <= cfg.ack_pending_value &&
                                 fc_q[2:0] == `MFHP_FT_CMD &&
                                 (cmd_q == `MFHP_DATA_REQ_CMD ||
                                  (fc_q[`MFHP_FC_VER_LSB + 1] &&
                                   fc_q[`MFHP_FC_SEC_BIT]));
            res_q.ack_seq <= seq_q;
            res_q.wait_ack <= is_tx_q && cfg.auto_retry_transmit_mode &&
                              fc_q[`MFHP_FC_ACKREQ_BIT];
            res_q.tx_done <= is_tx_q && cfg.auto_retry_transmit_mode &&
                             !fc_q[`MFHP_FC_ACKREQ_BIT];
        end
    end

    assign hdr = hdr_q;
    assign result = res_q;
    assign hdr_valid = done_q && (hdr_q.length != '0);

    // Header rate and durations
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            shr_cycles <= '0;
            phr_cycles <= '0;
            ack_deadline_cycles <= '0;
        end
        else
        begin
            unique case (cfg.rate)
                mfhp_pkg::MFHP_RATE_20:
                begin
                    shr_cycles <= 19'(`MFHP_CYC(`MFHP_SHR_US_20));
                    phr_cycles <= 18'(`MFHP_CYC(`MFHP_PHR_US_20));
                    ack_deadline_cycles <= 18'(`MFHP_CYC(`MFHP_ACK_SYMBOLS * 50));
                end
                mfhp_pkg::MFHP_RATE_40:
                begin
                    shr_cycles <= 19'(`MFHP_CYC(`MFHP_SHR_US_40));
                    phr_cycles <= 18'(`MFHP_CYC(`MFHP_PHR_US_40));
                    ack_deadline_cycles <= 18'(`MFHP_CYC(`MFHP_ACK_SYMBOLS * 25));
                end
                mfhp_pkg::MFHP_RATE_100, mfhp_pkg::MFHP_RATE_200,
                mfhp_pkg::MFHP_RATE_400:
                begin
                    shr_cycles <= 19'(`MFHP_CYC(`MFHP_SHR_US_100));
                    phr_cycles <= 18'(`MFHP_CYC(`MFHP_PHR_US_100));
                    ack_deadline_cycles <= 18'(`MFHP_CYC(`MFHP_ACK_SYMBOLS * 40));
                end
                mfhp_pkg::MFHP_RATE_250, mfhp_pkg::MFHP_RATE_500,
                mfhp_pkg::MFHP_RATE_1000:
                begin
                    shr_cycles <= 19'(`MFHP_CYC(`MFHP_SHR_US_250));
                    phr_cycles <= 18'(`MFHP_CYC(`MFHP_PHR_US_250));
                    ack_deadline_cycles <= 18'(`MFHP_CYC(`MFHP_ACK_SYMBOLS * 16));
                end
            endcase
        end
    end

    // PHR echo with top bit preserved
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phr_out <= 8'h00;
        end
        else if (oct_valid && st_q == ST_PHR)
        begin
            phr_out <= oct.data;
        end
    end
endmodule

`default_nettype wire

/* File: rtl/mfhp_consts.svh */
`ifndef MFHP_CONSTS_SVH
`define MFHP_CONSTS_SVH

// Frame control field positions
`define MFHP_FC_TYPE_LSB 0
`define MFHP_FC_SEC_BIT 3
`define MFHP_FC_PEND_BIT 4
`define MFHP_FC_ACKREQ_BIT 5
`define MFHP_FC_PANC_BIT 6
`define MFHP_FC_DMODE_LSB 10
`define MFHP_FC_VER_LSB 12
`define MFHP_FC_SMODE_LSB 14

// Frame types and address modes
`define MFHP_FT_BEACON 3'h0
`define MFHP_FT_DATA 3'h1
`define MFHP_FT_ACK 3'h2
`define MFHP_FT_CMD 3'h3
`define MFHP_FT_MAX_STD 3'h3
`define MFHP_AM_NONE 2'h0
`define MFHP_AM_RSVD 2'h1
`define MFHP_AM_SHORT 2'h2
`define MFHP_AM_EXT 2'h3

// Length classes
`define MFHP_LEN_ACK 7'h05
`define MFHP_LEN_MIN_MPDU 7'h09
`define MFHP_FCS_OCTETS 7'h02
`define MFHP_PAN_OCTETS 7'h02
`define MFHP_SHORT_OCTETS 7'h02
`define MFHP_EXT_OCTETS 7'h08
`define MFHP_DATA_REQ_CMD 8'h04
`define MFHP_BCAST_LO 8'hFF

// Header durations in us
`define MFHP_SHR_US_20 2000
`define MFHP_PHR_US_20 400
`define MFHP_SHR_US_40 1000
`define MFHP_PHR_US_40 200
`define MFHP_SHR_US_100 300
`define MFHP_PHR_US_100 80
`define MFHP_SHR_US_250 160
`define MFHP_PHR_US_250 32
`define MFHP_CLK_MHZ 250
`define MFHP_CYC(us) ((us) * `MFHP_CLK_MHZ)

// Acknowledge deadline
`define MFHP_ACK_SYMBOLS 12
`define MFHP_FIFO_DEPTH 4

`endif

/* File: rtl/mfhp_pkg.sv */
package mfhp_pkg;

    typedef enum logic [2:0]
    {
        MFHP_RATE_20 = 3'b000,
        MFHP_RATE_40 = 3'b001,
        MFHP_RATE_100 = 3'b010,
        MFHP_RATE_250 = 3'b011,
        MFHP_RATE_200 = 3'b100,
        MFHP_RATE_400 = 3'b101,
        MFHP_RATE_500 = 3'b110,
        MFHP_RATE_1000 = 3'b111
    } mfhp_rate_t;

    typedef enum logic [1:0]
    {
        MFHP_LC_RSVD = 2'b00,
        MFHP_LC_ACK = 2'b01,
        MFHP_LC_MPDU = 2'b10
    } mfhp_lclass_t;

    typedef struct packed
    {
        logic [7:0] data;
        logic first;
        logic last;
    } mfhp_octet_t;

    typedef struct packed
    {
        logic reserved_type_upload_enable;
        logic ack_pending_value;
        logic [1:0] version_accept_level;
        logic auto_ack_receive_mode;
        logic auto_retry_transmit_mode;
        mfhp_rate_t rate;
    } mfhp_cfg_t;

    typedef struct packed
    {
        logic [2:0] frame_type;
        logic security;
        logic pending;
        logic ack_request;
        logic pan_compress;
        logic [1:0] dst_mode;
        logic [1:0] version;
        logic [1:0] src_mode;
        logic [7:0] seq_num;
        logic [6:0] length;
        logic phr_msb;
        mfhp_lclass_t lclass;
        logic [6:0] dst_offset;
        logic [6:0] src_offset;
        logic [6:0] aux_offset;
        logic [6:0] fcs_offset;
        logic dst_bcast;
        logic data_request;
    } mfhp_hdr_t;

    typedef struct packed
    {
        logic filter_pass;
        logic report;
        logic send_ack;
        logic ack_pending;
        logic [7:0] ack_seq;
        logic wait_ack;
        logic tx_done;
    } mfhp_result_t;

endpackage

/* File: rtl/mfhp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module mfhp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: sim/mfhp_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module mfhp_partner (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rx_ready,
    output mfhp_pkg::mfhp_octet_t rx_octet,
    output logic rx_valid
);
    logic [7:0] q[$];
    logic [6:0] rem;
    logic tick;

    always @(posedge sys_clk)
    begin
        tick <= ~tick;
        if (rst)
        begin
            rx_valid <= 1'b0;
            rx_octet <= '0;
            rem <= 7'h00;
            tick <= 1'b0;
        end
        else if (!rx_valid || rx_ready)
        begin
            if (q.size() > 0 && (!slow || tick))
            begin
                rx_valid <= 1'b1;
                rx_octet.data <= q[0];
                rx_octet.first <= (rem == 7'h00);
                // Length octet, then exactly that many body octets
                rx_octet.last <= (rem == 7'h00) ? (q[0][6:0] == 7'h00)
                                                : (rem == 7'h01);
                rem <= (rem == 7'h00) ? q[0][6:0] : rem - 7'h01;
                q.pop_front();
            end
            else
            begin
                rx_valid <= 1'b0;
                rx_octet.data <= ~rx_octet.data;
            end
        end
    end
endmodule

`default_nettype wire

/* File: sim/mfhp_parser_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module mfhp_parser_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire mfhp_pkg::mfhp_octet_t rx_octet,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire mfhp_pkg::mfhp_cfg_t cfg,
    input wire mfhp_pkg::mfhp_hdr_t hdr,
    input wire logic hdr_valid,
    input wire mfhp_pkg::mfhp_result_t result,
    input wire logic [18:0] shr_cycles,
    input wire logic [17:0] phr_cycles,
    input wire logic [7:0] phr_out
);
    logic fast;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    assign fast = cfg.rate inside {mfhp_pkg::MFHP_RATE_250,
        mfhp_pkg::MFHP_RATE_500, mfhp_pkg::MFHP_RATE_1000};

    sequence s_zero_taken;
        rx_valid && rx_ready && rx_octet.first && rx_octet.data[6:0] == 7'h00;
    endsequence
    sequence s_tx_end;
        hdr_valid && !hdr.ack_request && !result.wait_ack ##1 !result.tx_done;
    endsequence

    property p_zero_len;
        s_zero_taken |=> !hdr_valid [*2];
    endproperty
    a_zero_len: assert property (p_zero_len)
        else $error("zero length frame reported");
    property p_len;
        hdr_valid |-> hdr.length != 7'h00 && hdr.length == phr_out[6:0]
            && hdr.phr_msb == phr_out[7];
    endproperty
    a_len: assert property (p_len)
        else $error("length field mismatch");
    property p_lclass;
        hdr_valid |-> hdr.lclass == (hdr.length == 7'h05 ? mfhp_pkg::MFHP_LC_ACK
            : hdr.length > 7'h08 ? mfhp_pkg::MFHP_LC_MPDU : mfhp_pkg::MFHP_LC_RSVD);
    endproperty
    a_lclass: assert property (p_lclass)
        else $error("length class wrong");
    property p_fcs;
        hdr_valid && hdr.length > 7'h08 |-> hdr.fcs_offset == hdr.length - 7'h02;
    endproperty
    a_fcs: assert property (p_fcs)
        else $error("checksum offset wrong");
    property p_ack;
        hdr_valid && result.send_ack |-> hdr.ack_request && !hdr.dst_bcast
            && cfg.auto_ack_receive_mode && hdr.frame_type inside {3'h1, 3'h3};
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack sent without cause");
    property p_ver;
        hdr_valid && hdr.version > cfg.version_accept_level |-> !result.send_ack;
    endproperty
    a_ver: assert property (p_ver)
        else $error("ack despite version");
    property p_ack_fields;
        hdr_valid && result.send_ack |-> result.ack_seq == hdr.seq_num
            && (!hdr.data_request || result.ack_pending == cfg.ack_pending_value);
    endproperty
    a_ack_fields: assert property (p_ack_fields)
        else $error("ack fields wrong");
    property p_rsvd;
        hdr_valid && hdr.frame_type > 3'h3 && !cfg.reserved_type_upload_enable
            |-> !result.filter_pass;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved type passed");
    property p_tx_done;
        result.tx_done |-> s_tx_end;
    endproperty
    a_tx_done: assert property (p_tx_done)
        else $error("transmit finish wrong");
    property p_hdr_time;
        fast [*3] |-> shr_cycles == 18'h09C40 && phr_cycles == 18'h01F40;
    endproperty
    a_hdr_time: assert property (p_hdr_time)
        else $error("header duration wrong");
    property p_dst;
        hdr_valid && hdr.dst_mode[1] |-> hdr.dst_offset == 7'h03;
    endproperty
    a_dst: assert property (p_dst)
        else $error("destination offset wrong");
endmodule

bind mfhp_parser mfhp_parser_properties mfhp_parser_properties_inst (
    .sys_clk(sys_clk), .rst(rst), .rx_octet(rx_octet), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .cfg(cfg), .hdr(hdr), .hdr_valid(hdr_valid),
    .result(result), .shr_cycles(shr_cycles), .phr_cycles(phr_cycles),
    .phr_out(phr_out)
);

`default_nettype wire

/* File: sim/mfhp_parser_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module mfhp_parser_test;
    logic sys_clk;
    logic rst;
    logic slow;
    logic rx_is_tx;
    logic rx_ready;
    logic rx_valid;
    logic hdr_valid;
    mfhp_pkg::mfhp_octet_t rx_octet;
    mfhp_pkg::mfhp_cfg_t cfg;
    mfhp_pkg::mfhp_hdr_t hdr;
    mfhp_pkg::mfhp_result_t result;
    logic [18:0] shr_cycles;
    logic [17:0] phr_cycles;
    logic [17:0] ack_deadline_cycles;
    logic [7:0] phr_out;
    logic [7:0] bq[$];
    int n_mismatch = 0;
    int compares = 0;
    int n_hv = 0;
    int cyc = 0;

    mfhp_parser mfhp_parser_inst (.sys_clk(sys_clk), .rst(rst),
        .rx_octet(rx_octet), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_is_tx(rx_is_tx), .cfg(cfg), .hdr(hdr), .hdr_valid(hdr_valid),
        .result(result), .shr_cycles(shr_cycles), .phr_cycles(phr_cycles),
        .ack_deadline_cycles(ack_deadline_cycles), .phr_out(phr_out));
    mfhp_partner mfhp_partner_inst (.sys_clk(sys_clk), .rst(rst),
        .slow(slow), .rx_ready(rx_ready), .rx_octet(rx_octet),
        .rx_valid(rx_valid));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (hdr_valid === 1'b1)
            n_hv <= n_hv + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic go(input logic [7:0] phr, input logic [15:0] fc,
                      input logic [7:0] s);
        int i;
        logic [13:0] ef;
        logic [13:0] gf;
        mfhp_pkg::mfhp_lclass_t lc;
        mfhp_partner_inst.q.push_back(phr);
        mfhp_partner_inst.q.push_back(fc[7:0]);
        mfhp_partner_inst.q.push_back(fc[15:8]);
        mfhp_partner_inst.q.push_back(s);
        foreach (bq[k])
            mfhp_partner_inst.q.push_back(bq[k]);
        for (i = 3 + bq.size(); i < phr[6:0]; i++)
            mfhp_partner_inst.q.push_back(8'hC3);
        bq.delete();
        for (i = 0; i < 400 && hdr_valid !== 1'b1; i++)
            @(negedge sys_clk);
        ef = {fc[2:0], fc[6:3], fc[11:10], fc[13:12], fc[15:14]};
        gf = {hdr.frame_type, hdr.pan_compress, hdr.ack_request, hdr.pending,
              hdr.security, hdr.dst_mode, hdr.version, hdr.src_mode};
        lc = phr[6:0] == 7'h05 ? mfhp_pkg::MFHP_LC_ACK
           : phr[6:0] > 7'h08 ? mfhp_pkg::MFHP_LC_MPDU : mfhp_pkg::MFHP_LC_RSVD;
        `CHK("hdr_valid", 1'b1, hdr_valid)
        `CHK("fcf", ef, gf)
        `CHK("seq", s, hdr.seq_num)
        `CHK("length", phr[6:0], hdr.length)
        `CHK("phr_msb", phr[7], hdr.phr_msb)
        `CHK("lclass", lc, hdr.lclass)
        if (phr[6:0] > 7'h08)
            `CHK("fcs_off", phr[6:0] - 7'h02, hdr.fcs_offset)
        @(negedge sys_clk);
    endtask

    task automatic t_rates();
        int shr[8] = '{2000, 1000, 300, 160, 300, 300, 160, 160};
        int phr[8] = '{400, 200, 80, 32, 80, 80, 32, 32};
        int sym[8] = '{50, 25, 40, 16, 40, 40, 16, 16};
        for (int r = 0; r < 8; r++)
        begin
            @(posedge sys_clk);
            cfg.rate <= mfhp_pkg::mfhp_rate_t'(r);
            repeat (2) @(negedge sys_clk);
            `CHK("shr", shr[r] * 250, shr_cycles)
            `CHK("phr", phr[r] * 250, phr_cycles)
            `CHK("ack_dl", sym[r] * 3000, ack_deadline_cycles)
        end
    endtask

    task automatic t_data();
        bq = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h01, 8'h02, 8'h03, 8'h04,
               8'h05, 8'h06, 8'h07, 8'h08};
        go(8'h93, 16'hD861, 8'h21);
        `CHK("dst_off", 7'h03, hdr.dst_offset)
        `CHK("src_off", 7'h07, hdr.src_offset)
        `CHK("send_ack", 1'b1, result.send_ack)
        `CHK("ack_seq", 8'h21, result.ack_seq)
        `CHK("pass", 1'b1, result.filter_pass)
        bq = '{8'h34, 8'h12, 8'hFF, 8'hFF, 8'h34, 8'h12, 8'h9A, 8'hBC};
        go(8'h0E, 16'h8821, 8'h22);
        `CHK("bcast", 1'b1, hdr.dst_bcast)
        `CHK("send_ack", 1'b0, result.send_ack)
    endtask

    task automatic t_loops();
        for (int p = 0; p < 2; p++)
        begin
            @(posedge sys_clk);
            cfg.ack_pending_value <= p[0];
            cfg.version_accept_level <= 2'(p + 1);
            cfg.reserved_type_upload_enable <= p[0];
            slow <= p[0];
            @(negedge sys_clk);
            bq = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h34, 8'h12, 8'h9A, 8'hBC, 8'h04};
            go(8'h0E, 16'h8823, 8'h40);
            `CHK("dreq", 1'b1, hdr.data_request)
            `CHK("pend", p[0], result.ack_pending)
            bq = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h34, 8'h12, 8'h9A, 8'hBC};
            go(8'h0E, 16'hA821, 8'h41);
            `CHK("ver_ack", p[0], result.send_ack)
            bq = '{8'h34, 8'h12, 8'h78, 8'h56};
            go(8'h0B, 16'h0805, 8'h42);
            `CHK("rsvd_pass", p[0], result.filter_pass)
            `CHK("report", p[0], result.report)
            bq = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h9A, 8'hBC, 8'h11, 8'h22};
            go(8'h14, p[0] ? 16'h9849 : 16'h9809, 8'h43);
            `CHK("aux_off", p[0] ? 7'h09 : 7'h0B, hdr.aux_offset)
        end
    endtask

    task automatic t_len_retry();
        int h;
        h = n_hv;
        mfhp_partner_inst.q.push_back(8'h00);
        repeat (30) @(negedge sys_clk);
        `CHK("zero_len", h, n_hv)
        go(8'h05, 16'h0002, 8'h50);
        go(8'h07, 16'h0002, 8'h51);
        go(8'h09, 16'h0002, 8'h52);
        @(posedge sys_clk);
        cfg.auto_retry_transmit_mode <= 1'b1;
        cfg.auto_ack_receive_mode <= 1'b0;
        rx_is_tx <= 1'b1;
        @(negedge sys_clk);
        for (int a = 0; a < 2; a++)
        begin
            bq = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h34, 8'h12, 8'h9A, 8'hBC};
            go(8'h0E, a ? 16'h8821 : 16'h8801, 8'h60);
            `CHK("wait_ack", a[0], result.wait_ack)
        end
    endtask

    task automatic t_tx_done();
        mfhp_partner_inst.q = '{8'h0B, 8'h01, 8'h08};
        repeat (9) mfhp_partner_inst.q.push_back(8'h61);
        for (int i = 0; i < 400 && hdr_valid !== 1'b1; i++)
            @(negedge sys_clk);
        `CHK("tx_done", 1'b1, result.tx_done)
        repeat (2) @(posedge sys_clk) rst <= ~rst;
        @(negedge sys_clk);
        `CHK("rst_phr", 8'h00, phr_out)
    endtask

    initial
    begin
        rst = 1'b1;
        slow = 1'b0;
        rx_is_tx = 1'b0;
        cfg = '0;
        cfg.auto_ack_receive_mode = 1'b1;
        cfg.version_accept_level = 2'h1;
        cfg.rate = mfhp_pkg::MFHP_RATE_250;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        `CHK("rx_ready", 1'b1, rx_ready)
        t_rates();
        t_data();
        t_loops();
        t_len_retry();
        t_tx_done();
        repeat (20) @(negedge sys_clk);
        give_verdict();
    end
endmodule

`default_nettype wire
